// ===== hw/lao_alu.sv
`default_nettype none

module lao_alu (
    input wire logic core_clk_i,                          // Core clock.
    input wire logic sys_rst_i,                           // Synchronous reset.
    input wire logic op_valid_i,                          // Operation request.
    input wire logic [lao_pkg::OP_W-1:0] op_code_i,       // Operation code.
    input wire logic [lao_pkg::ADDR_W-1:0] op_addr_i,     // Operand address.
    input wire logic [lao_pkg::BSEL_W-1:0] op_bit_i,      // Bit select.
    input wire logic ld_valid_i,                          // Memory preload.
    input wire logic [lao_pkg::ADDR_W-1:0] ld_addr_i,     // Preload address.
    input wire logic [lao_pkg::DATA_W-1:0] ld_data_i,     // Preload byte.
    output logic busy_o,                                  // Operation running.
    output logic done_o,                                  // Operation finished.
    output logic skip_o,                                  // Skip next fetch.
    output logic [lao_pkg::DATA_W-1:0] working_register_o, // Working register.
    output logic [lao_pkg::DATA_W-1:0] result_o,          // Byte produced.
    output logic carry_flag_o,                            // Carry flag.
    output logic null_flag_o,                             // Null flag.
    output logic signed_range_flag_o,                     // Signed range flag.
    output logic half_borrow_flag_o,                      // Half borrow flag.
    output logic signed_borrow_flag_o,                    // Signed borrow flag.
    output logic chained_null_flag_o                      // Chained null flag.
);

    // ------------------------------------------------------------------------
    // Memory and state.
    // ------------------------------------------------------------------------
    lao_mem_if mem_bus ();

    lao_dmem u_dmem (
        .core_clk_i(core_clk_i),
        .port(mem_bus.mem)
    );

    lao_pkg::lao_state_type s_reg;
    lao_pkg::lao_state_type s_next;

    logic [lao_pkg::DATA_W-1:0] mem_q;
    logic [lao_pkg::DATA_W:0] sub_res;
    logic [4:0] half_res;
    logic [lao_pkg::DATA_W-1:0] dec_res;
    logic [lao_pkg::DATA_W-1:0] bit_mask;
    logic sub_null;
    logic sub_ovf;
    logic op_take;

    assign mem_q = mem_bus.rd_data;
    assign op_take = (s_reg.st == lao_pkg::LAO_IDLE) && op_valid_i;

    // ------------------------------------------------------------------------
    // Arithmetic shared by the operations.
    // ------------------------------------------------------------------------

    // The borrow-in is the inverted carry; bit 8 set means a borrow out.
    assign sub_res = {1'b0, s_reg.acc} - {1'b0, mem_q} - {8'h00, ~s_reg.c};
    assign half_res = {1'b0, s_reg.acc[3:0]} - {1'b0, mem_q[3:0]} - {4'h0, ~s_reg.c};
    assign sub_null = (sub_res[lao_pkg::DATA_W-1:0] == lao_pkg::ZERO_BYTE);
    assign sub_ovf = (s_reg.acc[7] ^ mem_q[7]) & (s_reg.acc[7] ^ sub_res[7]);
    assign dec_res = mem_q - lao_pkg::ONE_BYTE;
    assign bit_mask = lao_pkg::ONE_BYTE << s_reg.bsel;

    // ------------------------------------------------------------------------
    // Memory port steering.
    // ------------------------------------------------------------------------

    // Reads use the latched address while an operation runs, so the byte is
    // ready in the execute cycle. Preloads are taken only when idle.
    always_comb begin
        mem_bus.rd_addr = (s_reg.st == lao_pkg::LAO_IDLE) ? op_addr_i : s_reg.addr;
        mem_bus.wr_en = 1'b0;
        mem_bus.wr_addr = s_reg.addr;
        mem_bus.wr_data = mem_q;
        if (s_reg.st == lao_pkg::LAO_EXEC) begin
            unique case (s_reg.op)
                lao_pkg::OP_SUB_WITH_BORROW_TO_MEM: begin
                    mem_bus.wr_en = 1'b1;
                    mem_bus.wr_data = sub_res[lao_pkg::DATA_W-1:0];
                end
                lao_pkg::OP_DEC_SKIP_NULL: begin
                    mem_bus.wr_en = 1'b1;
                    mem_bus.wr_data = dec_res;
                end
                lao_pkg::OP_FILL_ONES: begin
                    mem_bus.wr_en = 1'b1;
                    mem_bus.wr_data = lao_pkg::FILL_VALUE;
                end
                lao_pkg::OP_FILL_ONE_BIT: begin
                    mem_bus.wr_en = 1'b1;
                    mem_bus.wr_data = mem_q | bit_mask;
                end
                default: begin
                    mem_bus.wr_en = 1'b0;
                end
            endcase
        end else if (s_reg.st == lao_pkg::LAO_IDLE && ld_valid_i && !op_valid_i) begin
            mem_bus.wr_en = 1'b1;
            mem_bus.wr_addr = ld_addr_i;
            mem_bus.wr_data = ld_data_i;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer and datapath next state.
    // ------------------------------------------------------------------------

    // Flags change only in the execute cycle of the operations that own them.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.skip = 1'b0;
        unique case (s_reg.st)
            lao_pkg::LAO_IDLE: begin
                if (op_take) begin
                    s_next.st = lao_pkg::LAO_READ;
                    s_next.op = op_code_i;
                    s_next.addr = op_addr_i;
                    s_next.bsel = op_bit_i;
                    s_next.busy = 1'b1;
                end
            end
            lao_pkg::LAO_READ: begin
                s_next.st = lao_pkg::LAO_EXEC;
            end
            lao_pkg::LAO_EXEC: begin
                s_next.st = lao_pkg::LAO_IDLE;
                s_next.done = 1'b1;
                s_next.busy = 1'b0;
                s_next.result = mem_bus.wr_data;
                unique case (s_reg.op)
                    lao_pkg::OP_ROT_RIGHT_THRU_BORROW_TO_WORK: begin
                        s_next.acc = {s_reg.c, mem_q[7:1]};
                        s_next.c = mem_q[0];
                        s_next.result = {s_reg.c, mem_q[7:1]};
                    end
                    lao_pkg::OP_SUB_WITH_BORROW_TO_WORK,
                    lao_pkg::OP_SUB_WITH_BORROW_TO_MEM: begin
                        if (s_reg.op == lao_pkg::OP_SUB_WITH_BORROW_TO_WORK) begin
                            s_next.acc = sub_res[lao_pkg::DATA_W-1:0];
                        end
                        s_next.c = ~sub_res[lao_pkg::DATA_W];
                        s_next.z = sub_null;
                        s_next.ov = sub_ovf;
                        s_next.ac = ~half_res[4];
                        s_next.sc = sub_ovf ^ sub_res[7];
                        s_next.cz = sub_null & s_reg.cz;
                        s_next.result = sub_res[lao_pkg::DATA_W-1:0];
                    end
                    lao_pkg::OP_DEC_SKIP_NULL,
                    lao_pkg::OP_DEC_TO_WORK_SKIP_NULL: begin
                        if (s_reg.op == lao_pkg::OP_DEC_TO_WORK_SKIP_NULL) begin
                            s_next.acc = dec_res;
                        end
                        s_next.result = dec_res;
                        // A zero result holds the sequencer one extra cycle so
                        // the fetch side can insert its dummy instruction.
                        if (dec_res == lao_pkg::ZERO_BYTE) begin
                            s_next.st = lao_pkg::LAO_SKIP;
                            s_next.done = 1'b0;
                            s_next.busy = 1'b1;
                        end
                    end
                    default: begin
                        s_next.result = mem_bus.wr_data;
                    end
                endcase
            end
            lao_pkg::LAO_SKIP: begin
                s_next.st = lao_pkg::LAO_IDLE;
                s_next.done = 1'b1;
                s_next.skip = 1'b1;
                s_next.busy = 1'b0;
            end
        endcase
    end

    // Registered state; memory contents are not reset.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_reg <= '{st: lao_pkg::LAO_IDLE, acc: lao_pkg::ACC_RESET,
                       addr: lao_pkg::ADDR_RESET, result: lao_pkg::ZERO_BYTE,
                       default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy_o = s_reg.busy;
    assign done_o = s_reg.done;
    assign skip_o = s_reg.skip;
    assign working_register_o = s_reg.acc;
    assign result_o = s_reg.result;
    assign carry_flag_o = s_reg.c;
    assign null_flag_o = s_reg.z;
    assign signed_range_flag_o = s_reg.ov;
    assign half_borrow_flag_o = s_reg.ac;
    assign signed_borrow_flag_o = s_reg.sc;
    assign chained_null_flag_o = s_reg.cz;

    // ------------------------------------------------------------------------
    // Assertions and covers.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic in_exec;
    logic [5:0] flag_vec;
    assign in_exec = (s_reg.st == lao_pkg::LAO_EXEC);
    assign flag_vec = {s_reg.c, s_reg.z, s_reg.ov, s_reg.ac, s_reg.sc, s_reg.cz};

    property p_rot;
        in_exec && s_reg.op == lao_pkg::OP_ROT_RIGHT_THRU_BORROW_TO_WORK |=>
            s_reg.acc == {$past(s_reg.c), $past(mem_q[7:1])} && s_reg.c == $past(mem_q[0]);
    endproperty
    a_rot: assert property (p_rot) else $error("Rotate result wrong.");

    property p_sub_work;
        in_exec && s_reg.op == lao_pkg::OP_SUB_WITH_BORROW_TO_WORK |->
            !mem_bus.wr_en ##1 s_reg.acc == $past(sub_res[7:0]);
    endproperty
    a_sub_work: assert property (p_sub_work) else $error("Subtract to working wrong.");

    property p_sub_mem;
        in_exec && s_reg.op == lao_pkg::OP_SUB_WITH_BORROW_TO_MEM |->
            mem_bus.wr_en && mem_bus.wr_data == sub_res[7:0] ##1 $stable(s_reg.acc);
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("Subtract to memory wrong.");

    property p_sub_carry;
        in_exec && (s_reg.op == lao_pkg::OP_SUB_WITH_BORROW_TO_WORK ||
            s_reg.op == lao_pkg::OP_SUB_WITH_BORROW_TO_MEM) |=>
            s_reg.c == !$past(sub_res[8]) && s_reg.z == $past(sub_null);
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("Subtract flags wrong.");

    property p_dec_mem;
        in_exec && s_reg.op == lao_pkg::OP_DEC_SKIP_NULL |->
            mem_bus.wr_en && mem_bus.wr_data == mem_q - 8'h01 ##1
            (s_reg.st == lao_pkg::LAO_SKIP) == ($past(dec_res) == 8'h00) && $stable(flag_vec);
    endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("Decrement memory wrong.");

    property p_dec_work;
        in_exec && s_reg.op == lao_pkg::OP_DEC_TO_WORK_SKIP_NULL |->
            !mem_bus.wr_en ##1 s_reg.acc == $past(dec_res) && $stable(flag_vec);
    endproperty
    a_dec_work: assert property (p_dec_work) else $error("Decrement to working wrong.");

    property p_skip_len;
        $rose(s_reg.st == lao_pkg::LAO_SKIP) |-> !done_o ##1 done_o && skip_o &&
            s_reg.st == lao_pkg::LAO_IDLE ##1 !skip_o;
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("Skip timing wrong.");

    property p_fill;
        in_exec && s_reg.op == lao_pkg::OP_FILL_ONES |->
            mem_bus.wr_en && mem_bus.wr_data == 8'hFF ##1 $stable(flag_vec);
    endproperty
    a_fill: assert property (p_fill) else $error("Fill ones wrong.");

    property p_bit;
        in_exec && s_reg.op == lao_pkg::OP_FILL_ONE_BIT |->
            mem_bus.wr_en && mem_bus.wr_data == (mem_q | (8'h01 << s_reg.bsel)) ##1
            $stable(flag_vec);
    endproperty
    a_bit: assert property (p_bit) else $error("Bit set wrong.");

    property p_seq;
        op_take |=> s_reg.st == lao_pkg::LAO_READ ##1 in_exec ##1 s_reg.st != lao_pkg::LAO_READ;
    endproperty
    a_seq: assert property (p_seq) else $error("Sequencer order wrong.");

    c_skip: cover property (skip_o);
    c_sub_neg: cover property (in_exec && s_reg.op == lao_pkg::OP_SUB_WITH_BORROW_TO_WORK
        && sub_res[8]);
    c_bit: cover property (in_exec && s_reg.op == lao_pkg::OP_FILL_ONE_BIT);

endmodule : lao_alu

`default_nettype wire

// ===== hw/lao_pkg.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Shared constants and types of the far-address ALU subset.
// ----------------------------------------------------------------------------
package lao_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int OP_W = 3;
    localparam int BSEL_W = 3;

    // Operation codes of the local decode scheme.
    localparam logic [OP_W-1:0] OP_ROT_RIGHT_THRU_BORROW_TO_WORK = 3'h0;
    localparam logic [OP_W-1:0] OP_SUB_WITH_BORROW_TO_WORK = 3'h1;
    localparam logic [OP_W-1:0] OP_SUB_WITH_BORROW_TO_MEM = 3'h2;
    localparam logic [OP_W-1:0] OP_DEC_SKIP_NULL = 3'h3;
    localparam logic [OP_W-1:0] OP_DEC_TO_WORK_SKIP_NULL = 3'h4;
    localparam logic [OP_W-1:0] OP_FILL_ONES = 3'h5;
    localparam logic [OP_W-1:0] OP_FILL_ONE_BIT = 3'h6;
    localparam logic [OP_W-1:0] OP_PEEK = 3'h7;

    // Values and reset states.
    localparam logic [DATA_W-1:0] FILL_VALUE = 8'hFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;

    // Sequencer states, Gray coded along idle, read, execute, skip.
    typedef enum logic [1:0] {
        LAO_IDLE = 2'h0,
        LAO_READ = 2'h1,
        LAO_EXEC = 2'h3,
        LAO_SKIP = 2'h2
    } lao_state_enum_type;

    typedef struct packed {
        lao_state_enum_type st;
        logic [DATA_W-1:0] acc;
        logic c;
        logic z;
        logic ov;
        logic ac;
        logic sc;
        logic cz;
        logic [ADDR_W-1:0] addr;
        logic [OP_W-1:0] op;
        logic [BSEL_W-1:0] bsel;
        logic done;
        logic skip;
        logic busy;
        logic [DATA_W-1:0] result;
    } lao_state_type;

endpackage : lao_pkg

`default_nettype wire

// ===== hw/lao_mem_if.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Data memory port between the datapath and its byte store.
// ----------------------------------------------------------------------------
interface lao_mem_if;
    logic [lao_pkg::ADDR_W-1:0] rd_addr;
    logic [lao_pkg::DATA_W-1:0] rd_data;
    logic wr_en;
    logic [lao_pkg::ADDR_W-1:0] wr_addr;
    logic [lao_pkg::DATA_W-1:0] wr_data;

    modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data,
                  input rd_data);
    modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data,
                 output rd_data);
endinterface : lao_mem_if

`default_nettype wire

// ===== hw/lao_dmem.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Byte-wide data memory with a registered read port.
// ----------------------------------------------------------------------------
module lao_dmem (
    input wire logic core_clk_i, // Core instruction clock.
    lao_mem_if.mem port          // Read and write port.
);

    logic [lao_pkg::DATA_W-1:0] mem_array [lao_pkg::MEM_DEPTH];
    logic [lao_pkg::DATA_W-1:0] rd_data_reg;

    // The array has no reset; its contents are undefined until written.
    always_ff @(posedge core_clk_i) begin
        if (port.wr_en) begin
            mem_array[port.wr_addr] <= port.wr_data;
        end
        rd_data_reg <= mem_array[port.rd_addr]; // Old data on a same-address write.
    end

    assign port.rd_data = rd_data_reg;

endmodule : lao_dmem

`default_nettype wire

// ===== test/lao_fetch_model.sv
`default_nettype none

// ----------------------------------------------------------------------------
// Instruction fetch sequencer model: issues operations, follows skips.
// ----------------------------------------------------------------------------
module lao_fetch_model (
    input wire logic core_clk_i,                       // Core clock.
    input wire logic done_i,                           // Operation finished.
    input wire logic skip_i,                           // Skip next fetch.
    output logic op_valid_o,                           // Operation request.
    output logic [lao_pkg::OP_W-1:0] op_code_o,        // Operation code.
    output logic [lao_pkg::ADDR_W-1:0] op_addr_o,      // Operand address.
    output logic [lao_pkg::BSEL_W-1:0] op_bit_o,       // Bit select.
    output logic [7:0] pc_o                            // Program counter.
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle values at time zero.
    initial begin
        op_valid_o = 1'b0;
        op_code_o = 3'h0;
        op_addr_o = 8'h00;
        op_bit_o = 3'h0;
        pc_o = 8'h00;
    end

    // One request, held up to its take edge, then waited on with a bound.
    task automatic issue(input logic [2:0] code, input logic [7:0] addr,
                         input logic [2:0] bsel, output int cyc, output logic skp);
        @(negedge core_clk_i);
        op_valid_o = 1'b1;
        op_code_o = code;
        op_addr_o = addr;
        op_bit_o = bsel;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        // Released address and bit select are scrambled so a stale sample cannot pass.
        op_valid_o = 1'b0;
        op_addr_o = ~addr;
        op_bit_o = ~bsel;
        // The take edge counts as the first cycle of the operation.
        cyc = 1;
        do begin
            @(posedge core_clk_i);
            cyc++;
            @(negedge core_clk_i);
        end while (done_i !== 1'b1 && cyc < 10);
        skp = (skip_i === 1'b1);
        // A skipped instruction is stepped over, not fetched.
        pc_o = pc_o + (skp ? 8'h02 : 8'h01);
    endtask : issue

endmodule : lao_fetch_model

`default_nettype wire

// ===== test/long_addr_alu_ops_subset_test.sv
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH time=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module long_addr_alu_ops_subset_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------------
    // Signals and instances.
    // ------------------------------------------------------------------------
    logic core_clk_i, sys_rst_i, ld_valid, op_valid, busy, done, skip, cz_m;
    logic [7:0] ld_addr, ld_data, op_addr, acc, result, pc;
    logic [2:0] op_code, op_bit;
    logic c_f, z_f, ov_f, ac_f, sc_f, cz_f;
    logic [5:0] flg;
    int error_cnt = 0;
    int num_checks = 0;
    int busy_cyc = 0;
    logic [7:0] a_tab [5] = '{8'h50, 8'h00, 8'h80, 8'h10, 8'h7F};
    logic [7:0] m_tab [5] = '{8'h20, 8'h01, 8'h01, 8'h0F, 8'hFF};
    logic c_tab [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    // Flags gathered so one compare covers all six.
    assign flg = {c_f, z_f, ov_f, ac_f, sc_f, cz_f};

    // Busy cycles are counted off the sampling edge, where the level is settled.
    always @(negedge core_clk_i) begin
        if (busy === 1'b1) begin
            busy_cyc++;
        end
    end

    lao_alu DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid),
        .op_code_i(op_code), .op_addr_i(op_addr), .op_bit_i(op_bit), .ld_valid_i(ld_valid),
        .ld_addr_i(ld_addr), .ld_data_i(ld_data), .busy_o(busy), .done_o(done),
        .skip_o(skip), .working_register_o(acc), .result_o(result), .carry_flag_o(c_f),
        .null_flag_o(z_f), .signed_range_flag_o(ov_f), .half_borrow_flag_o(ac_f),
        .signed_borrow_flag_o(sc_f), .chained_null_flag_o(cz_f));

    lao_fetch_model FETCH (.core_clk_i(core_clk_i), .done_i(done), .skip_i(skip),
        .op_valid_o(op_valid), .op_code_o(op_code), .op_addr_o(op_addr),
        .op_bit_o(op_bit), .pc_o(pc));

    // Clock generator, 50 ns period.
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------------
    task automatic end_of_test();
        $display("Checks: %0d  Errors: %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [13:0] sub_model(input logic [7:0] a, m, input logic c, cz);
        logic [8:0] r;
        logic [4:0] h;
        logic ov;
        r = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
        h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
        ov = (a[7] ^ m[7]) & (a[7] ^ r[7]);
        return {r[7:0], ~r[8], r[7:0] == 8'h00, ov, ~h[4], ov ^ r[7], (r[7:0] == 8'h00) & cz};
    endfunction : sub_model

    task automatic load(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk_i);
        ld_valid = 1'b1;
        ld_addr = addr;
        ld_data = data;
        @(negedge core_clk_i);
        // The stale preload byte is inverted while the strobe is low.
        ld_valid = 1'b0;
        ld_data = ~data;
    endtask : load

    task automatic op(input logic [2:0] code, input logic [7:0] addr, input logic [2:0] bsel,
                      input int exp_cyc);
        int cyc;
        logic skp;
        logic [7:0] pc0;
        int b0;
        pc0 = pc;
        b0 = busy_cyc;
        FETCH.issue(code, addr, bsel, cyc, skp);
        `CHK(cyc, exp_cyc);
        `CHK(skp, 1'(exp_cyc == 4));
        `CHK(pc, pc0 + 8'(exp_cyc - 2));
        `CHK(busy_cyc - b0, exp_cyc - 1);
    endtask : op

    task automatic peek(input logic [7:0] addr, output logic [7:0] v);
        op(lao_pkg::OP_PEEK, addr, 3'h0, 3);
        v = result;
    endtask : peek

    // ------------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------------
    task automatic t_sub(input logic [2:0] code);
        logic [13:0] e;
        logic [7:0] v;
        for (int k = 0; k < 5; k++) begin
            load(8'h10, {7'h00, c_tab[k]});
            op(lao_pkg::OP_ROT_RIGHT_THRU_BORROW_TO_WORK, 8'h10, 3'h0, 3);
            load(8'h11, a_tab[k] + 8'h01);
            op(lao_pkg::OP_DEC_TO_WORK_SKIP_NULL, 8'h11, 3'h0, (a_tab[k] == 8'h00) ? 4 : 3);
            load(8'h12, m_tab[k]);
            op(code, 8'h12, 3'h0, 3);
            e = sub_model(a_tab[k], m_tab[k], c_tab[k], cz_m);
            cz_m = e[0];
            `CHK(flg, e[5:0]);
            if (code == lao_pkg::OP_SUB_WITH_BORROW_TO_WORK) begin
                `CHK(acc, e[13:6]);
            end else begin
                `CHK(acc, a_tab[k]);
                peek(8'h12, v);
                `CHK(v, e[13:6]);
            end
        end
    endtask : t_sub

    task automatic t_rotate();
        logic [5:0] pre;
        logic [7:0] v;
        load(8'h20, 8'h81);
        load(8'h10, 8'h00);
        op(lao_pkg::OP_ROT_RIGHT_THRU_BORROW_TO_WORK, 8'h10, 3'h0, 3);
        pre = flg;
        op(lao_pkg::OP_ROT_RIGHT_THRU_BORROW_TO_WORK, 8'h20, 3'h0, 3);
        `CHK({acc, c_f}, {8'h40, 1'b1});
        `CHK(flg[4:0], pre[4:0]);
        peek(8'h20, v);
        `CHK(v, 8'h81);
        load(8'h21, 8'h02);
        op(lao_pkg::OP_ROT_RIGHT_THRU_BORROW_TO_WORK, 8'h21, 3'h0, 3);
        `CHK({acc, c_f}, {8'h81, 1'b0});
    endtask : t_rotate

    task automatic t_dec();
        logic [5:0] pre;
        logic [7:0] v;
        pre = flg;
        load(8'h30, 8'h01);
        op(lao_pkg::OP_DEC_SKIP_NULL, 8'h30, 3'h0, 4);
        peek(8'h30, v);
        `CHK(v, 8'h00);
        load(8'h31, 8'h00);
        op(lao_pkg::OP_DEC_SKIP_NULL, 8'h31, 3'h0, 3);
        peek(8'h31, v);
        `CHK(v, 8'hFF);
        load(8'h40, 8'h01);
        op(lao_pkg::OP_DEC_TO_WORK_SKIP_NULL, 8'h40, 3'h0, 4);
        `CHK(acc, 8'h00);
        peek(8'h40, v);
        `CHK(v, 8'h01);
        load(8'h41, 8'h80);
        op(lao_pkg::OP_DEC_TO_WORK_SKIP_NULL, 8'h41, 3'h0, 3);
        `CHK(acc, 8'h7F);
        `CHK(flg, pre);
    endtask : t_dec

    task automatic t_fill();
        logic [5:0] pre;
        logic [7:0] v, acc0;
        pre = flg;
        acc0 = acc;
        load(8'h50, 8'h12);
        op(lao_pkg::OP_FILL_ONES, 8'h50, 3'h0, 3);
        peek(8'h50, v);
        `CHK(v, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            load(8'h60 + 8'(i), 8'h24);
            op(lao_pkg::OP_FILL_ONE_BIT, 8'h60 + 8'(i), 3'(i), 3);
            peek(8'h60 + 8'(i), v);
            `CHK(v, 8'h24 | (8'h01 << i));
        end
        `CHK({flg, acc}, {pre, acc0});
    endtask : t_fill

    // Watchdog: the whole sequence needs well under 2000 cycles.
    initial begin
        #(50 * 5000);
        error_cnt++;
        end_of_test();
    end

    // Main sequence: 16 reset cycles, then every scenario in turn.
    initial begin
        sys_rst_i = 1'b1;
        ld_valid = 1'b0;
        ld_addr = 8'h00;
        ld_data = 8'h00;
        cz_m = 1'b0;
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        t_sub(lao_pkg::OP_SUB_WITH_BORROW_TO_WORK);
        t_sub(lao_pkg::OP_SUB_WITH_BORROW_TO_MEM);
        t_rotate();
        t_dec();
        t_fill();
        end_of_test();
    end

endmodule : long_addr_alu_ops_subset_test

`default_nettype wire
